// *** hdl/bms_boot_mode_select.v ***
// Implementation choices: the placing of the registers and strobed register access.
`include "bms_defs.vh"
`default_nettype none
// Overview of operation
// - Strap high with link strap low selects byte-wide EPROM boot; with link strap high it is reserved
// - Strap low: link strap and select decide
// - 0 0 1 selects host processor boot
// - 0 1 1 selects link port boot
// - Select low, link strap low: no boot, external execution; link strap high is reserved
// - EPROM mode drives select as chip select
// - Only bus owner drives select output
// - Select is driven only in EPROM mode and floats in all other modes
// - Reset restarts at hardware reset vector
// - One instruction per input clock period
module bsel_boot_mode_select (
    // Clock and reset
    input  wire                      CLK,
    input  wire                      RESET,
    // Straps and boot memory select pin
    input  wire                      EPROM_BOOT_STRAP,
    input  wire                      LINK_BOOT_STRAP,
    input  wire                      BOOT_MEMORY_SELECT_N_LEVEL,
    output reg                       BOOT_MEMORY_SELECT_N,
    output reg                       BOOT_MEMORY_SELECT_N_OE_N,
    // Boot loader request
    input  wire                      EPROM_ACCESS,
    output reg  [`BSEL_MODE_W-1:0]   BOOT_MODE,
    output reg                       FETCH_ENABLE,
    output reg  [`BSEL_DATA_W-1:0]   FETCH_ADDR,
    // Register port
    input  wire [`BSEL_ADDR_W-1:0]   REG_ADDR,
    input  wire [`BSEL_DATA_W-1:0]   REG_WDATA,
    input  wire                      REG_WR,
    input  wire                      REG_RD,
    output reg  [`BSEL_DATA_W-1:0]   REG_RDATA
);

// ****************************************
// Run states
// ****************************************
localparam [1:0]           ST_RESET = 2'h0;
localparam [1:0]           ST_FETCH = 2'h1;

// ****************************************
// Pin synchronisers
// ****************************************
reg  [2:0]                 sync1_ff;
reg  [2:0]                 sync2_ff;

always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        sync1_ff <= `BSEL_SYNC_RESET;
        sync2_ff <= `BSEL_SYNC_RESET;
    end else begin
        sync1_ff <= {EPROM_BOOT_STRAP, LINK_BOOT_STRAP, BOOT_MEMORY_SELECT_N_LEVEL};
        sync2_ff <= sync1_ff;
    end
end

wire                       eb_s = sync2_ff[2];
wire                       lb_s = sync2_ff[1];
wire                       bs_s = sync2_ff[0];

// ****************************************
// Mode decode
// ****************************************
reg  [`BSEL_MODE_W-1:0]    dec_mode;

always @* begin
    if (eb_s) begin
        dec_mode = lb_s ? `BSEL_MODE_RSVD : `BSEL_MODE_EPROM;
    end else if (!bs_s) begin
        dec_mode = lb_s ? `BSEL_MODE_RSVD : `BSEL_MODE_NONE;
    end else if (lb_s) begin
        dec_mode = `BSEL_MODE_LINK;
    end else begin
        dec_mode = `BSEL_MODE_HOST;
    end
end

// ****************************************
// Strap capture and run state
// ****************************************
reg  [1:0]                 state_ff;
reg  [1:0]                 nxt_state;
reg  [`BSEL_MODE_W-1:0]    mode_ff;
reg  [`BSEL_MODE_W-1:0]    nxt_mode;
reg  [1:0]                 settle_ff;

always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        settle_ff <= `BSEL_SETTLE_RESET;
    end else if (settle_ff != `BSEL_SETTLE_LAST) begin
        settle_ff <= settle_ff + 2'h1;
    end
end

always @* begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    case (state_ff)
        ST_RESET: begin
            nxt_mode = dec_mode;
            if (settle_ff == `BSEL_SETTLE_LAST) begin
                nxt_state = ST_FETCH;
            end
        end
        ST_FETCH: begin
            nxt_state = ST_FETCH;
        end
        default: begin
            nxt_state = ST_RESET;
        end
    endcase
end

always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        state_ff <= ST_RESET;
        mode_ff  <= `BSEL_MODE_NONE;
    end else begin
        state_ff <= nxt_state;
        mode_ff  <= nxt_mode;
    end
end

wire                       running = (state_ff == ST_FETCH);
wire                       eprom_mode = (mode_ff == `BSEL_MODE_EPROM);

// ****************************************
// Control register
// ****************************************
reg  [1:0]                 ctrl_ff;
reg  [`BSEL_DATA_W-1:0]    cycles_ff;

always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        ctrl_ff <= `BSEL_CTRL_RESET;
    end else if (REG_WR && REG_ADDR == `BSEL_REG_CTRL) begin
        ctrl_ff <= REG_WDATA[1:0];
    end
end

// ****************************************
// Instruction fetch sequencing
// ****************************************
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        FETCH_ENABLE <= 1'b0;
        FETCH_ADDR   <= `BSEL_RESET_VECTOR;
        BOOT_MODE    <= `BSEL_MODE_NONE;
        cycles_ff    <= 32'h0;
    end else begin
        BOOT_MODE    <= mode_ff;
        FETCH_ENABLE <= running;
        // First fetch stands at the reset vector
        if (FETCH_ENABLE) begin
            FETCH_ADDR <= FETCH_ADDR + 32'h1;
            cycles_ff  <= cycles_ff + 32'h1;
        end
    end
end

// ****************************************
// Boot memory select pin drive
// ****************************************
wire                       drive = eprom_mode && ctrl_ff[`BSEL_CTRL_OWN_BIT];

always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        BOOT_MEMORY_SELECT_N      <= 1'b1;
        BOOT_MEMORY_SELECT_N_OE_N <= 1'b1;
    end else begin
        BOOT_MEMORY_SELECT_N_OE_N <= ~(drive && ctrl_ff[`BSEL_CTRL_ENA_BIT]);
        BOOT_MEMORY_SELECT_N      <= ~(drive && EPROM_ACCESS);
    end
end

// ****************************************
// Register read port
// ****************************************
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
        case (REG_ADDR)
            `BSEL_REG_STATUS: REG_RDATA <= {28'h0, running, mode_ff};
            `BSEL_REG_CTRL:   REG_RDATA <= {30'h0, ctrl_ff};
            `BSEL_REG_VECTOR: REG_RDATA <= `BSEL_RESET_VECTOR;
            `BSEL_REG_CYCLES: REG_RDATA <= cycles_ff;
            default:         REG_RDATA <= 32'h0;
        endcase
    end else begin
        REG_RDATA <= 32'h0;
    end
end

endmodule // bsel_boot_mode_select
`default_nettype wire

// *** hdl/bms_defs.vh ***
`ifndef BSEL_DEFS_VH
`define BSEL_DEFS_VH
// ****************************************
// Boot mode codes
// ****************************************
`define BSEL_MODE_W         3
`define BSEL_MODE_NONE      3'h0
`define BSEL_MODE_HOST      3'h1
`define BSEL_MODE_LINK      3'h2
`define BSEL_MODE_EPROM     3'h3
`define BSEL_MODE_RSVD      3'h4
// ****************************************
// Register map
// ****************************************
`define BSEL_ADDR_W         4
`define BSEL_DATA_W         32
`define BSEL_REG_STATUS     4'h0
`define BSEL_REG_CTRL       4'h4
`define BSEL_REG_VECTOR     4'h8
`define BSEL_REG_CYCLES     4'hC
`define BSEL_CTRL_ENA_BIT   0
`define BSEL_CTRL_OWN_BIT   1
`define BSEL_CTRL_RESET     2'h0
`define BSEL_RESET_VECTOR   32'h00020004
// ****************************************
// Timing and reset values
// ****************************************
`define BSEL_SETTLE_LAST    2'h3
`define BSEL_SETTLE_RESET   2'h0
`define BSEL_SYNC_RESET     3'h0
`endif

// *** verification/bmsel_asserts.sv ***
`include "bms_defs.vh"
`default_nettype none
// ****************************************
// Port checks
// ****************************************
module bsel_asserts (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // Pin and loader
    input wire logic        EPROM_ACCESS,
    input wire logic        BOOT_MEMORY_SELECT_N,
    input wire logic        BOOT_MEMORY_SELECT_N_OE_N,
    // Mode and fetch
    input wire logic [2:0]  BOOT_MODE,
    input wire logic        FETCH_ENABLE,
    input wire logic [31:0] FETCH_ADDR,
    // Register port
    input wire logic        REG_RD,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [31:0] REG_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_stat_rd; REG_RD && REG_ADDR == `BSEL_REG_STATUS; endsequence
    sequence s_wait; !FETCH_ENABLE [*4] ##[1:2] FETCH_ENABLE; endsequence
    property p_oe; !BOOT_MEMORY_SELECT_N_OE_N |-> BOOT_MODE == `BSEL_MODE_EPROM; endproperty
    property p_cs; !BOOT_MEMORY_SELECT_N |-> BOOT_MODE == `BSEL_MODE_EPROM; endproperty
    property p_own; !EPROM_ACCESS |=> BOOT_MEMORY_SELECT_N; endproperty
    property p_run; FETCH_ENABLE |=> FETCH_ADDR == $past(FETCH_ADDR) + 32'h1; endproperty
    property p_vec; $rose(FETCH_ENABLE) |-> FETCH_ADDR == `BSEL_RESET_VECTOR; endproperty
    property p_start; $fell(RESET) |-> s_wait; endproperty
    property p_hold; FETCH_ENABLE |=> $stable(BOOT_MODE); endproperty
    property p_stat; s_stat_rd |=> REG_RDATA[2:0] == BOOT_MODE && REG_RDATA[31:4] == 28'h0; endproperty
    a_oe: assert property (p_oe) else $error("pin enabled outside eprom mode");
    a_cs: assert property (p_cs) else $error("chip select outside eprom mode");
    a_own: assert property (p_own) else $error("chip select without access");
    a_run: assert property (p_run) else $error("fetch address not stepping");
    a_vec: assert property (p_vec) else $error("fetch not at reset vector");
    a_start: assert property (p_start) else $error("fetch start late");
    a_hold: assert property (p_hold) else $error("mode moved while running");
    a_stat: assert property (p_stat) else $error("status read wrong");
endmodule // bsel_asserts
bind bsel_boot_mode_select bsel_asserts chk_u (.*);
`default_nettype wire

// *** verification/bmsel_eprom_model.sv ***
`default_nettype none
// ****************************************
// Boot EPROM and board strap on the select pin
// ****************************************
module bsel_eprom_model (
    // Clock, strap level and pin drive
    input  wire logic clk,
    input  wire logic cfg_n,
    input  wire logic cs_n,
    input  wire logic oe_n,
    // Pin level and selects seen
    output wire logic pin_n,
    output var  int   hits
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pin falls back to the strap level
    assign pin_n = oe_n ? cfg_n : cs_n;
    initial hits = 0;
    always @(posedge clk) begin
        if (!oe_n && !cs_n) begin
            hits <= hits + 1;
        end
    end
endmodule // bsel_eprom_model
`default_nettype wire

// *** verification/tb_boot_mode_select.sv ***
`include "bms_defs.vh"
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
// ****************************************
// Bench
// ****************************************
module tb_boot_mode_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK = 0, RESET = 1, EPROM_BOOT_STRAP = 0, LINK_BOOT_STRAP = 0, cfg_n = 1, EPROM_ACCESS = 0;
    logic        REG_WR = 0, REG_RD = 0, cs_n, oe_n, pin_n, fe;
    logic [2:0]  mode;
    logic [3:0]  REG_ADDR = 4'h0;
    logic [31:0] REG_WDATA = 32'h0, fa, rdata;
    logic [5:0]  tbl [5] = '{6'h2B, 6'h09, 6'h1A, 6'h00, 6'h23};
    int          hits, fail_count = 0, comparisons = 0;
    always #25 CLK = ~CLK;
    bsel_boot_mode_select dut_u (.CLK(CLK), .RESET(RESET), .EPROM_BOOT_STRAP(EPROM_BOOT_STRAP),
        .LINK_BOOT_STRAP(LINK_BOOT_STRAP), .BOOT_MEMORY_SELECT_N_LEVEL(pin_n), .BOOT_MEMORY_SELECT_N(cs_n),
        .BOOT_MEMORY_SELECT_N_OE_N(oe_n), .EPROM_ACCESS(EPROM_ACCESS), .BOOT_MODE(mode), .FETCH_ENABLE(fe),
        .FETCH_ADDR(fa), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(rdata));
    bsel_eprom_model part_u (.clk(CLK), .cfg_n(cfg_n), .cs_n(cs_n), .oe_n(oe_n), .pin_n(pin_n), .hits(hits));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'h1;
        @(posedge CLK);
        REG_WR <= 1'h0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        REG_ADDR <= a;
        REG_RD <= 1'h1;
        @(posedge CLK);
        REG_RD <= 1'h0;
        #1 `CHK(rdata, e)
        @(posedge CLK);
    endtask
    task automatic boot(input logic [5:0] c);
        RESET <= 1'h1;
        {EPROM_BOOT_STRAP, LINK_BOOT_STRAP, cfg_n} <= c[5:3];
        repeat (12) @(posedge CLK);
        #1 `CHK({fe, fa}, {1'h0, `BSEL_RESET_VECTOR})
        @(posedge CLK);
        RESET <= 1'h0;
        repeat (10) @(posedge CLK);
    endtask
    task print_verdict;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 5; i++) begin
            boot(tbl[i]);
            `CHK({fe, mode}, {1'h1, tbl[i][2:0]})
            rd(`BSEL_REG_CYCLES, 32'h5);
            rd(`BSEL_REG_STATUS, {28'h0, 1'h1, tbl[i][2:0]});
            rd(`BSEL_REG_CTRL, 32'h0);
            wr(`BSEL_REG_VECTOR, 32'h0);
            rd(`BSEL_REG_VECTOR, `BSEL_RESET_VECTOR);
            wr(`BSEL_REG_CTRL, 32'h3);
            EPROM_ACCESS <= 1'h1;
            repeat (3) @(posedge CLK);
            #1 `CHK({oe_n, cs_n}, {2{mode != `BSEL_MODE_EPROM}})
            `CHK(mode, tbl[i][2:0])
            @(posedge CLK);
            wr(`BSEL_REG_CTRL, 32'h1);
            repeat (2) @(posedge CLK);
            #1 `CHK({oe_n, cs_n}, 2'h3)
            @(posedge CLK);
            EPROM_ACCESS <= 1'h0;
            $display("test %0d done", i);
        end
        `CHK(hits > 0, 1'h1)
        print_verdict();
    end
    initial begin
        #100us;
        fail_count++;
        print_verdict();
    end
endmodule // tb_boot_mode_select
`default_nettype wire
